/* rtl/dual_timer_counter.sv */
// Design decisions made here: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "timer_defs.svh"

// Overview of operation
// - Counter-select clear counts machine cycles, set counts external pin events.
// - Each timer has its own two-bit mode field; modes 0-2 match.
// - Mode 0 is a 13-bit counter; rollover sets the overflow flag.
// - Mode 0 uses high byte plus low five bits; upper three ignored.
// - Counting only while run is set and gate clear or gate pin high; split timer zero's high byte ignores gate, timer one ignores run.
// - Setting run never alters the count registers.
// - Gate bits sit at mode bit 7 (timer one) and bit 3.
// - Mode 1 counts over the full cascaded 16 bits.
// - Mode 2 low byte overflows set flag and reload from high byte.
// - Timer one in mode 3 holds its count as if stopped.
// - Timer zero mode 3 low byte is an 8-bit counter on own controls.
// - Split high byte counts cycles, runs on run_one, sets overflow_one.
// - Split mode: timer one stops in mode 3, still feeds baud ticks.
// - Overflow flags set by hardware, cleared on interrupt vectoring.
// - Software sets or clears run bits at control bits 6 and 4.
// - External edge flags set on detected edge, cleared when processed.
// - Type bit set means falling-edge, clear means low-level triggering.
// - Timer function increments once per machine cycle of twelve clocks.
// - Count pin sampled per machine cycle; high then low increments.
// - Mode codes: 00 prescale13, 01 count16, 10 reload8, 11 split.
module dual_timer_counter
  import timer_pkg::*;
(
  // Clock and reset
  input  wire logic                  core_clk,
  input  wire logic                  rst,
  // Register port
  input  wire logic [`REG_ADDR_W-1:0] regAddr,
  input  wire logic [7:0]            wrData,
  input  wire logic                  wrStrobe,
  input  wire logic                  rdStrobe,
  output logic      [7:0]            rdData,
  // Pins
  input  wire logic                  countPinZero,
  input  wire logic                  countPinOne,
  input  wire logic                  gatePinZero,
  input  wire logic                  gatePinOne,
  // Interrupt vectoring acknowledges
  input  wire logic                  ackTimerZero,
  input  wire logic                  ackTimerOne,
  input  wire logic                  ackExtZero,
  input  wire logic                  ackExtOne,
  // Requests and baud tick
  output logic                       irqTimerZero,
  output logic                       irqTimerOne,
  output logic                       irqExtZero,
  output logic                       irqExtOne,
  output logic                       baudTick
);

  // --------------------------------------------------------------------------
  // Machine cycle and pin samplers
  // --------------------------------------------------------------------------
  logic       mcEn;
  logic [1:0] countPins;
  logic [1:0] pinFall;

  assign countPins = {countPinOne, countPinZero};

  machine_cycle_gen u_mc (
    .core_clk (core_clk),
    .rst      (rst),
    .mcEn     (mcEn)
  );

  for (genvar i = 0; i < 2; i++) begin : g_pin
    pin_fall_sampler u_fall (
      .core_clk (core_clk),
      .rst      (rst),
      .mcEn     (mcEn),
      .pin      (countPins[i]),
      .fall     (pinFall[i])
    );
  end

  // --------------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------------
  logic [7:0] timerControl;
  logic [7:0] modeControl;
  countPair_t count0;
  countPair_t count1;
  logic       gatePrevZero;
  logic       gatePrevOne;

  logic [7:0] next_timerControl;
  logic [7:0] next_modeControl;
  countPair_t next_count0;
  countPair_t next_count1;
  logic [7:0] next_rdData;
  logic       next_baudTick;

  timerMode_t  mode0;
  timerMode_t  mode1;
  logic        tick0;
  logic        tick1;
  logic        tickHigh0;
  logic        split0;
  logic        ovf0Event;
  logic        ovf1Event;
  stepResult_t step0;
  stepResult_t step1;
  logic        extEvent0;
  logic        extEvent1;

  function automatic stepResult_t advance(timerMode_t m, countPair_t c, logic tick);
    stepResult_t r;
    r.ovf  = 1'b0;
    r.pair = c;
    if (tick) begin
      case (m)
        MODE_PRESCALE13: begin
          // Upper three low bits are left alone; software must ignore them.
          r.pair.low[4:0] = c.low[4:0] + 5'h01;
          if (&c.low[4:0]) begin
            r.pair.high = c.high + 8'h01;
            r.ovf       = &c.high;
          end
        end
        MODE_COUNT16: begin
          r.pair = c + 16'h0001;
          r.ovf  = &c;
        end
        MODE_RELOAD8: begin
          r.pair.low = c.low + 8'h01;
          if (&c.low) begin
            r.pair.low = c.high;
            r.ovf      = 1'b1;
          end
        end
        default: begin
          r.pair.low = c.low + 8'h01;
          r.ovf      = &c.low;
        end
      endcase
    end
    return r;
  endfunction : advance

  // --------------------------------------------------------------------------
  // Next-state logic
  // --------------------------------------------------------------------------
  always_comb begin
    mode0  = timerMode_t'(modeControl[`MD_MODE_ZERO_HI:`MD_MODE_ZERO_LO]);
    mode1  = timerMode_t'(modeControl[`MD_MODE_ONE_HI:`MD_MODE_ONE_LO]);
    split0 = (mode0 == MODE_SPLIT);

    tick0 = timerControl[`TC_RUN_ZERO]
          & (~modeControl[`MD_GATE_ZERO] | gatePinZero)
          & (modeControl[`MD_CT_ZERO] ? pinFall[0] : mcEn);

    // While timer zero is split its high byte owns run_one, so timer one is
    // switched only by its own mode 3 and, with its gate bit set, by gatePinOne.
    tick1 = (split0 | timerControl[`TC_RUN_ONE])
          & (mode1 != MODE_SPLIT)
          & (~modeControl[`MD_GATE_ONE] | gatePinOne)
          & (modeControl[`MD_CT_ONE] ? pinFall[1] : mcEn);

    tickHigh0 = split0 & timerControl[`TC_RUN_ONE] & mcEn;

    step0 = advance(mode0, count0, tick0);
    step1 = advance(mode1, count1, tick1);

    next_count0 = step0.pair;
    ovf0Event   = step0.ovf;
    ovf1Event   = step1.ovf & ~split0;
    if (split0) begin
      next_count0.high = count0.high + {7'h00, tickHigh0};
      ovf1Event        = tickHigh0 & (&count0.high);
    end
    next_count1   = step1.pair;
    next_baudTick = step1.ovf;

    extEvent0 = timerControl[`TC_EXT_TYPE_ZERO] ? (gatePrevZero & ~gatePinZero) : ~gatePinZero;
    extEvent1 = timerControl[`TC_EXT_TYPE_ONE] ? (gatePrevOne & ~gatePinOne) : ~gatePinOne;

    next_modeControl  = modeControl;
    next_timerControl = timerControl;
    if (wrStrobe) begin
      case (regAddr)
        `ADDR_TIMER_CONTROL:   next_timerControl = wrData;
        `ADDR_MODE_CONTROL:    next_modeControl  = wrData;
        `ADDR_COUNT_LOW_ZERO:  next_count0.low   = wrData;
        `ADDR_COUNT_HIGH_ZERO: next_count0.high  = wrData;
        `ADDR_COUNT_LOW_ONE:   next_count1.low   = wrData;
        `ADDR_COUNT_HIGH_ONE:  next_count1.high  = wrData;
        default: ;
      endcase
    end

    // Vectoring clears first, hardware sets last so that a set always wins.
    if (ackTimerZero) next_timerControl[`TC_OVF_ZERO]     = 1'b0;
    if (ackTimerOne)  next_timerControl[`TC_OVF_ONE]      = 1'b0;
    if (ackExtZero)   next_timerControl[`TC_EXT_FLAG_ZERO] = 1'b0;
    if (ackExtOne)    next_timerControl[`TC_EXT_FLAG_ONE]  = 1'b0;
    if (ovf0Event)    next_timerControl[`TC_OVF_ZERO]     = 1'b1;
    if (ovf1Event)    next_timerControl[`TC_OVF_ONE]      = 1'b1;
    if (extEvent0)    next_timerControl[`TC_EXT_FLAG_ZERO] = 1'b1;
    if (extEvent1)    next_timerControl[`TC_EXT_FLAG_ONE]  = 1'b1;

    next_rdData = `RESET_BYTE;
    if (rdStrobe) begin
      case (regAddr)
        `ADDR_TIMER_CONTROL:   next_rdData = timerControl;
        `ADDR_MODE_CONTROL:    next_rdData = modeControl;
        `ADDR_COUNT_LOW_ZERO:  next_rdData = count0.low;
        `ADDR_COUNT_HIGH_ZERO: next_rdData = count0.high;
        `ADDR_COUNT_LOW_ONE:   next_rdData = count1.low;
        `ADDR_COUNT_HIGH_ONE:  next_rdData = count1.high;
        default:               next_rdData = `RESET_BYTE;
      endcase
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      timerControl <= `RESET_BYTE;
      modeControl  <= `RESET_BYTE;
      count0       <= '0;
      count1       <= '0;
      gatePrevZero <= 1'b0;
      gatePrevOne  <= 1'b0;
      rdData       <= `RESET_BYTE;
      baudTick     <= 1'b0;
    end else begin
      timerControl <= next_timerControl;
      modeControl  <= next_modeControl;
      count0       <= next_count0;
      count1       <= next_count1;
      gatePrevZero <= gatePinZero;
      gatePrevOne  <= gatePinOne;
      rdData       <= next_rdData;
      baudTick     <= next_baudTick;
    end
  end

  assign irqTimerZero = timerControl[`TC_OVF_ZERO];
  assign irqTimerOne  = timerControl[`TC_OVF_ONE];
  assign irqExtZero   = timerControl[`TC_EXT_FLAG_ZERO];
  assign irqExtOne    = timerControl[`TC_EXT_FLAG_ONE];

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  logic wrCount0;
  logic wrCount1;
  assign wrCount0 = wrStrobe & (regAddr == `ADDR_COUNT_LOW_ZERO | regAddr == `ADDR_COUNT_HIGH_ZERO);
  assign wrCount1 = wrStrobe & (regAddr == `ADDR_COUNT_LOW_ONE | regAddr == `ADDR_COUNT_HIGH_ONE);

  property p_mc_period;
    @(posedge core_clk) disable iff (rst) mcEn |-> ##12 mcEn;
  endproperty
  a_mc_period: assert property (p_mc_period) else $error("machine cycle not twelve clocks");

  property p_stopped_low;
    @(posedge core_clk) disable iff (rst)
      (!timerControl[`TC_RUN_ZERO] && !wrCount0) |=> (count0.low == $past(count0.low));
  endproperty
  a_stopped_low: assert property (p_stopped_low) else $error("timer zero counted while stopped");

  property p_hold_mode3;
    @(posedge core_clk) disable iff (rst) (mode1 == MODE_SPLIT && !wrCount1) |=> $stable(count1);
  endproperty
  a_hold_mode3: assert property (p_hold_mode3) else $error("timer one moved in mode 3");

  property p_wrap16;
    @(posedge core_clk) disable iff (rst)
      (tick0 && mode0 == MODE_COUNT16 && &count0 && !wrCount0)
        |=> (count0 == '0 && timerControl[`TC_OVF_ZERO]);
  endproperty
  a_wrap16: assert property (p_wrap16) else $error("16-bit wrap wrong");

  property p_reload;
    @(posedge core_clk) disable iff (rst)
      (tick0 && mode0 == MODE_RELOAD8 && &count0.low && !wrCount0)
        |=> (count0.low == $past(count0.high) && $stable(count0.high) && timerControl[`TC_OVF_ZERO]);
  endproperty
  a_reload: assert property (p_reload) else $error("auto-reload wrong");

  property p_prescale;
    @(posedge core_clk) disable iff (rst)
      (tick0 && mode0 == MODE_PRESCALE13 && &count0.low[4:0] && !(&count0.high) && !wrCount0)
        |=> (count0.high == $past(count0.high) + 8'h01 && count0.low[7:5] == $past(count0.low[7:5]));
  endproperty
  a_prescale: assert property (p_prescale) else $error("13-bit carry wrong");

  property p_write_wins;
    @(posedge core_clk) disable iff (rst)
      (wrStrobe && regAddr == `ADDR_COUNT_LOW_ONE) |=> (count1.low == $past(wrData));
  endproperty
  a_write_wins: assert property (p_write_wins) else $error("count write lost");

  property p_set_wins;
    @(posedge core_clk) disable iff (rst) (ovf1Event && ackTimerOne) |=> irqTimerOne;
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("overflow set lost to clear");

  property p_ext_edge;
    @(posedge core_clk) disable iff (rst)
      (timerControl[`TC_EXT_TYPE_ZERO] && gatePrevZero && !gatePinZero) |=> irqExtZero;
  endproperty
  a_ext_edge: assert property (p_ext_edge) else $error("falling edge not flagged");

  property p_split_high;
    @(posedge core_clk) disable iff (rst)
      (tickHigh0 && &count0.high && !wrCount0) |=> (irqTimerOne && count0.high == 8'h00);
  endproperty
  a_split_high: assert property (p_split_high) else $error("split high overflow wrong");

  c_baud:   cover property (@(posedge core_clk) disable iff (rst) baudTick);
  c_split:  cover property (@(posedge core_clk) disable iff (rst) tickHigh0 && &count0.high);
  c_reload: cover property (@(posedge core_clk) disable iff (rst) tick0 && mode0 == MODE_RELOAD8 && &count0.low);
  c_count:  cover property (@(posedge core_clk) disable iff (rst) tick0 && modeControl[`MD_CT_ZERO]);

endmodule : dual_timer_counter

/* rtl/timer_defs.svh */
`ifndef TIMER_DEFS_SVH
`define TIMER_DEFS_SVH

// ----------------------------------------------------------------------------
// Register addresses
// ----------------------------------------------------------------------------
`define REG_ADDR_W            3
`define ADDR_TIMER_CONTROL    3'h0
`define ADDR_MODE_CONTROL     3'h1
`define ADDR_COUNT_LOW_ZERO   3'h2
`define ADDR_COUNT_HIGH_ZERO  3'h3
`define ADDR_COUNT_LOW_ONE    3'h4
`define ADDR_COUNT_HIGH_ONE   3'h5

// ----------------------------------------------------------------------------
// timer_control fields
// ----------------------------------------------------------------------------
`define TC_OVF_ONE            7
`define TC_RUN_ONE            6
`define TC_OVF_ZERO           5
`define TC_RUN_ZERO           4
`define TC_EXT_FLAG_ONE       3
`define TC_EXT_TYPE_ONE       2
`define TC_EXT_FLAG_ZERO      1
`define TC_EXT_TYPE_ZERO      0

// ----------------------------------------------------------------------------
// mode_control_reg fields
// ----------------------------------------------------------------------------
`define MD_GATE_ONE           7
`define MD_CT_ONE             6
`define MD_MODE_ONE_HI        5
`define MD_MODE_ONE_LO        4
`define MD_GATE_ZERO          3
`define MD_CT_ZERO            2
`define MD_MODE_ZERO_HI       1
`define MD_MODE_ZERO_LO       0

// ----------------------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------------------
`define RESET_BYTE            8'h00
`define MC_OSC_PERIODS        4'hC
`define MC_CNT_W              4

`endif

/* rtl/timer_pkg.sv */
package timer_pkg;

  typedef enum logic [1:0] {
    MODE_PRESCALE13,
    MODE_COUNT16,
    MODE_RELOAD8,
    MODE_SPLIT
  } timerMode_t;

  typedef struct packed {
    logic [7:0] high;
    logic [7:0] low;
  } countPair_t;

  typedef struct packed {
    logic       ovf;
    countPair_t pair;
  } stepResult_t;

endpackage : timer_pkg

/* rtl/machine_cycle_gen.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"

module machine_cycle_gen (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Machine cycle enable
  output logic      mcEn
);

  logic [`MC_CNT_W-1:0] phase;
  logic [`MC_CNT_W-1:0] next_phase;
  logic                 next_mcEn;

  always_comb begin
    next_phase = phase + `MC_CNT_W'(1);
    next_mcEn  = 1'b0;
    if (phase == `MC_OSC_PERIODS - `MC_CNT_W'(1)) begin
      next_phase = '0;
      next_mcEn  = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      phase <= '0;
      mcEn  <= 1'b0;
    end else begin
      phase <= next_phase;
      mcEn  <= next_mcEn;
    end
  end

endmodule : machine_cycle_gen

/* rtl/pin_fall_sampler.sv */
`timescale 1ns/1ps

module pin_fall_sampler (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic rst,
  // Sampling
  input  wire logic mcEn,
  input  wire logic pin,
  output logic      fall
);

  logic lastSample;
  logic next_lastSample;

  // The pin is looked at once per machine cycle, so a level shorter than one
  // machine cycle may be missed entirely.
  always_comb begin
    next_lastSample = mcEn ? pin : lastSample;
    fall            = mcEn & lastSample & ~pin;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      lastSample <= 1'b0;
    end else begin
      lastSample <= next_lastSample;
    end
  end

endmodule : pin_fall_sampler

/* bench/count_pin_source.sv */
`timescale 1ns/1ps

module count_pin_source (
  // Clock
  input  wire logic core_clk,
  // Pins toward the timers
  output logic      countPinZero,
  output logic      countPinOne,
  output logic      gatePinZero,
  output logic      gatePinOne
);
  // ----------------------------------------------------------------
  // Pin levels
  // ----------------------------------------------------------------
  // Pins rest high so that no stray falling edge is seen between events.
  initial begin
    countPinZero = 1'b1;
    countPinOne  = 1'b1;
    gatePinZero  = 1'b1;
    gatePinOne   = 1'b1;
  end

  // Each level is held two machine cycles, so a sample can never miss it.
  task automatic pulse(input int which);
    if (which == 0) begin
      countPinZero <= 1'b0;
    end else begin
      countPinOne <= 1'b0;
    end
    repeat (24) @(posedge core_clk);
    if (which == 0) begin
      countPinZero <= 1'b1;
    end else begin
      countPinOne <= 1'b1;
    end
    repeat (24) @(posedge core_clk);
  endtask : pulse

  task automatic setGate(input int which, input logic level);
    if (which == 0) begin
      gatePinZero <= level;
    end else begin
      gatePinOne <= level;
    end
    @(posedge core_clk);
  endtask : setGate
endmodule : count_pin_source

/* bench/test_dual_timer_counter.sv */
`timescale 1ns/1ps
`include "timer_defs.svh"

module test_dual_timer_counter
  import timer_pkg::*;
;
  logic                   core_clk;
  logic                   rst;
  logic [`REG_ADDR_W-1:0] regAddr;
  logic [7:0]             wrData;
  logic                   wrStrobe;
  logic                   rdStrobe;
  logic [7:0]             rdData;
  wire logic              countPinZero;
  wire logic              countPinOne;
  wire logic              gatePinZero;
  wire logic              gatePinOne;
  logic [3:0]             acks;
  logic [3:0]             irqs;
  logic                   baudTick;
  int                     failCount;
  int                     compares;

  dual_timer_counter i_dut (
    .core_clk     (core_clk),
    .rst          (rst),
    .regAddr      (regAddr),
    .wrData       (wrData),
    .wrStrobe     (wrStrobe),
    .rdStrobe     (rdStrobe),
    .rdData       (rdData),
    .countPinZero (countPinZero),
    .countPinOne  (countPinOne),
    .gatePinZero  (gatePinZero),
    .gatePinOne   (gatePinOne),
    .ackTimerZero (acks[0]),
    .ackTimerOne  (acks[1]),
    .ackExtZero   (acks[2]),
    .ackExtOne    (acks[3]),
    .irqTimerZero (irqs[0]),
    .irqTimerOne  (irqs[1]),
    .irqExtZero   (irqs[2]),
    .irqExtOne    (irqs[3]),
    .baudTick     (baudTick)
  );

  count_pin_source i_pins (
    .core_clk     (core_clk),
    .countPinZero (countPinZero),
    .countPinOne  (countPinOne),
    .gatePinZero  (gatePinZero),
    .gatePinOne   (gatePinOne)
  );

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failCount++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Bus tasks are entered at a rising edge and drive by non-blocking assignment. Each one lets
  // an edge pass after its strobe falls, so no strobe is assigned twice in one time step.
  task automatic wr(input logic [2:0] a, input logic [7:0] d);
    regAddr  <= a;
    wrData   <= d;
    wrStrobe <= 1'b1;
    @(posedge core_clk);
    wrStrobe <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  // Read data stand only until the next edge, so they are taken at that edge before it moves.
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    regAddr  <= a;
    rdStrobe <= 1'b1;
    @(posedge core_clk);
    rdStrobe <= 1'b0;
    @(posedge core_clk);
    d = rdData;
  endtask : rd

  task automatic rdChk(input logic [2:0] a, input logic [7:0] exp, input string what);
    logic [7:0] d;
    rd(a, d);
    chk(what, exp, d);
  endtask : rdChk

  // Two reads whose strobes lie exactly gap clocks apart; the count must move by exp.
  task automatic rateChk(input logic [2:0] a, input int gap, input logic [7:0] exp, input string what);
    logic [7:0] x;
    logic [7:0] y;
    rd(a, x);
    repeat (gap - 2) @(posedge core_clk);
    rd(a, y);
    chk(what, exp, y - x);
  endtask : rateChk

  task automatic waitIrq(input int which, input int limit, input string what);
    int n;
    n = 0;
    while (irqs[which] !== 1'b1 && n < limit) begin
      @(posedge core_clk);
      n++;
    end
    chk(what, 8'h01, {7'h00, irqs[which]});
  endtask : waitIrq

  task automatic ack(input int which);
    acks[which] <= 1'b1;
    @(posedge core_clk);
    acks[which] <= 1'b0;
    @(posedge core_clk);
    chk("flag after ack", 8'h00, {7'h00, irqs[which]});
  endtask : ack

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic testReset();
    for (int a = 0; a < 7; a++) begin
      rdChk(a[2:0], 8'h00, "reset value");
    end
    @(posedge core_clk);
    chk("rdData idle", 8'h00, rdData);
  endtask : testReset

  task automatic testSixteen();
    wr(`ADDR_MODE_CONTROL, 8'h01);
    wr(`ADDR_COUNT_LOW_ZERO, 8'h00);
    wr(`ADDR_COUNT_HIGH_ZERO, 8'h00);
    wr(`ADDR_TIMER_CONTROL, 8'h10);
    rateChk(`ADDR_COUNT_LOW_ZERO, 120, 8'h0A, "ticks in 120 clocks");
    wr(`ADDR_COUNT_HIGH_ZERO, 8'hFF);
    wr(`ADDR_COUNT_LOW_ZERO, 8'hFC);
    waitIrq(0, 60, "overflow zero 16 bit");
    rdChk(`ADDR_COUNT_HIGH_ZERO, 8'h00, "high after wrap");
    ack(0);
    wr(`ADDR_TIMER_CONTROL, 8'h00);
  endtask : testSixteen

  task automatic testThirteen();
    wr(`ADDR_MODE_CONTROL, 8'h00);
    wr(`ADDR_COUNT_LOW_ZERO, 8'hFE);
    wr(`ADDR_COUNT_HIGH_ZERO, 8'hFF);
    wr(`ADDR_TIMER_CONTROL, 8'h10);
    waitIrq(0, 40, "overflow zero 13 bit");
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    rdChk(`ADDR_COUNT_LOW_ZERO, 8'hE0, "low after 13 bit wrap");
    rdChk(`ADDR_COUNT_HIGH_ZERO, 8'h00, "high after 13 bit wrap");
  endtask : testThirteen

  task automatic testGate();
    wr(`ADDR_MODE_CONTROL, 8'h08);
    wr(`ADDR_COUNT_LOW_ZERO, 8'h55);
    wr(`ADDR_COUNT_HIGH_ZERO, 8'h12);
    i_pins.setGate(0, 1'b0);
    wr(`ADDR_TIMER_CONTROL, 8'h10);
    rdChk(`ADDR_COUNT_LOW_ZERO, 8'h55, "low after run set");
    repeat (60) @(posedge core_clk);
    rdChk(`ADDR_COUNT_LOW_ZERO, 8'h55, "low while gated");
    rdChk(`ADDR_COUNT_HIGH_ZERO, 8'h12, "high while gated");
    i_pins.setGate(0, 1'b1);
    rateChk(`ADDR_COUNT_LOW_ZERO, 36, 8'h03, "ticks with gate high");
    wr(`ADDR_TIMER_CONTROL, 8'h00);
  endtask : testGate

  task automatic testReload();
    wr(`ADDR_MODE_CONTROL, 8'h20);
    wr(`ADDR_COUNT_HIGH_ONE, 8'hF0);
    wr(`ADDR_COUNT_LOW_ONE, 8'hFE);
    wr(`ADDR_TIMER_CONTROL, 8'h40);
    waitIrq(1, 40, "overflow one reload");
    chk("baud tick", 8'h01, {7'h00, baudTick});
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    rdChk(`ADDR_COUNT_LOW_ONE, 8'hF0, "low reloaded");
    rdChk(`ADDR_COUNT_HIGH_ONE, 8'hF0, "reload value kept");
  endtask : testReload

  task automatic testCounter();
    wr(`ADDR_MODE_CONTROL, 8'h05);
    wr(`ADDR_COUNT_LOW_ZERO, 8'h00);
    wr(`ADDR_COUNT_HIGH_ZERO, 8'h00);
    wr(`ADDR_TIMER_CONTROL, 8'h10);
    repeat (3) i_pins.pulse(0);
    rdChk(`ADDR_COUNT_LOW_ZERO, 8'h03, "pin events");
    wr(`ADDR_MODE_CONTROL, 8'h0D);
    i_pins.setGate(0, 1'b0);
    repeat (2) i_pins.pulse(0);
    i_pins.setGate(0, 1'b1);
    rdChk(`ADDR_COUNT_LOW_ZERO, 8'h03, "gated pin events");
    wr(`ADDR_TIMER_CONTROL, 8'h00);
  endtask : testCounter

  task automatic testSplit();
    wr(`ADDR_MODE_CONTROL, 8'h33);
    wr(`ADDR_COUNT_LOW_ZERO, 8'h40);
    wr(`ADDR_COUNT_HIGH_ZERO, 8'hFE);
    wr(`ADDR_COUNT_LOW_ONE, 8'h77);
    wr(`ADDR_TIMER_CONTROL, 8'h40);
    waitIrq(1, 40, "split high overflow");
    chk("flag zero in split", 8'h00, {7'h00, irqs[0]});
    wr(`ADDR_TIMER_CONTROL, 8'h00);
    rdChk(`ADDR_COUNT_HIGH_ZERO, 8'h00, "split high wrap");
    rdChk(`ADDR_COUNT_LOW_ZERO, 8'h40, "split low idle");
    rdChk(`ADDR_COUNT_LOW_ONE, 8'h77, "timer one held");
  endtask : testSplit

  // Timer one leaves its own mode 3 while timer zero stays split: it must run without its run
  // bit and give a baud tick every second machine cycle, but never touch overflow_one.
  task automatic testSplitBaud();
    int n;
    n = 0;
    wr(`ADDR_COUNT_HIGH_ONE, 8'hFE);
    wr(`ADDR_COUNT_LOW_ONE, 8'hFE);
    wr(`ADDR_MODE_CONTROL, 8'h23);
    repeat (48) begin
      @(posedge core_clk);
      n += baudTick;
    end
    chk("baud ticks in split", 8'h02, n[7:0]);
    chk("flag one in split", 8'h00, {7'h00, irqs[1]});
  endtask : testSplitBaud

  task automatic testExternal();
    for (int i = 0; i < 2; i++) begin
      wr(`ADDR_TIMER_CONTROL, (i == 0) ? 8'h01 : 8'h04);
      ack(2 + i);
      i_pins.setGate(i, 1'b0);
      waitIrq(2 + i, 4, "edge flag");
      i_pins.setGate(i, 1'b1);
      ack(2 + i);
    end
    wr(`ADDR_TIMER_CONTROL, 8'h00);
  endtask : testExternal

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", compares, failCount);
    if (failCount == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end

  // The whole sequence needs about 800 clocks; the limit leaves wide margin.
  initial begin
    #(25 * 20000);
    failCount++;
    report_and_stop();
  end

  initial begin
    rst       = 1'b1;
    regAddr   = '0;
    wrData    = 8'h00;
    wrStrobe  = 1'b0;
    rdStrobe  = 1'b0;
    acks      = 4'h0;
    failCount = 0;
    compares  = 0;
    repeat (3) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    testReset();
    testSixteen();
    testThirteen();
    testGate();
    testReload();
    testCounter();
    testSplit();
    testSplitBaud();
    testExternal();
    report_and_stop();
  end
endmodule : test_dual_timer_counter
